// [prh_defines.svh]
`ifndef PRH_DEFINES_SVH
`define PRH_DEFINES_SVH

// ==========================================================
// command codes
`define PRH_OP_IN 8'h5E
`define PRH_OP_OUT 8'h5F
`define PRH_PARAM_LEN 16'h0018

// ==========================================================
// reserve-in service actions
`define PRH_IN_READ_KEYS 5'h00
`define PRH_IN_READ_RES 5'h01
`define PRH_IN_LAST 5'h03

// ==========================================================
// reserve-out service actions
`define PRH_SA_REGISTER 5'h00
`define PRH_SA_RESERVE 5'h01
`define PRH_SA_RELEASE 5'h02
`define PRH_SA_CLEAR 5'h03
`define PRH_SA_PREEMPT 5'h04
`define PRH_SA_PREEMPT_ABORT 5'h05
`define PRH_SA_REGISTER_IGNORE 5'h06

// ==========================================================
// reservation types
`define PRH_TYPE_WR_EXCL 4'h1
`define PRH_TYPE_EXCL 4'h3
`define PRH_TYPE_WR_EXCL_REG 4'h5
`define PRH_TYPE_EXCL_REG 4'h6

// ==========================================================
// sizes and reset values
`define PRH_INITIATORS 8
`define PRH_KEY_BYTES 4'h8
`define PRH_DESC_BYTES 32'h0000_0010
`define PRH_GEN_RESET 32'h0000_0000

`endif

// [prh_pkg.sv]
package prh_pkg;

  typedef enum logic [1:0] {
    STS_GOOD = 2'h0,
    STS_CHECK = 2'h1,
    STS_CONFLICT = 2'h2
  } status_t;

  typedef enum logic [1:0] {
    SNS_NONE = 2'h0,
    SNS_PARAM_LEN = 2'h1,
    SNS_BAD_FIELD = 2'h2
  } sense_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CHECK = 8'h02,
    S_SCAN = 8'h04,
    S_SCMP = 8'h08,
    S_FETCH = 8'h10,
    S_LOAD = 8'h20,
    S_SEND = 8'h40,
    S_DONE = 8'h80
  } state_t;

endpackage

// [prh_key_ram.sv]
`timescale 1ns/1ps
// ==========================================================
// registered-key store, one 64-bit word per initiator
module prh_key_ram (
  // clock
  input logic clk,
  // write port
  input logic we,
  input logic [2:0] waddr,
  input logic [63:0] wdata,
  // read port, data one cycle after re
  input logic re,
  input logic [2:0] raddr,
  output logic [63:0] rdata
);

  logic [63:0] mem [0:7];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

// [persistent_reservation_handler.sv]
`timescale 1ns/1ps
`include "prh_defines.svh"

// Operation
// RULE_01: 32-bit generation counts register/clear/preempt actions
// RULE_02: generation unchanged by reads, reserve, release, errors
// RULE_03: power-on and hard reset zero generation
// RULE_04: read-keys data: generation, length, keys
// RULE_05: read-keys length counts full key list
// RULE_06: stop at allocation length, no error
// RULE_07: key list holds every registered initiator
// RULE_08: read-reservations: generation, length, optional descriptor
// RULE_09: descriptor: key, address, scope/type, zero extent
// RULE_10: descriptor length unaffected by truncation
// RULE_11: reserve-out command block field layout
// RULE_12: parameter length not 18h gives check condition
// RULE_13: legacy reserve active gives reservation conflict (code does this for reserve-out only; reserve-in commands still run)
// RULE_14: decode reserve-out actions, 07h-1Fh reserved
// RULE_15: clear drops all keys and reservations
// RULE_16: preempt-and-abort also aborts victim task set
// RULE_17: host avoids mixing legacy and persistent commands
// RULE_18: reserve-in actions 00h-03h, others invalid field
// RULE_19: only types 1h,3h,5h,6h accepted (code checks type for reserve and preempt only)
// RULE_20: supplied key must match, except register variants
// RULE_21: generation wraps to zero after maximum
module persistent_reservation_handler (
  // clock and reset
  input logic clk,
  input logic arst_n,
  input logic hard_reset,
  // legacy reserve state
  input logic legacy_reserved,
  // command block
  input logic cmd_valid,
  output logic cmd_ready,
  input logic [7:0] cmd_opcode,
  input logic [4:0] cmd_action,
  input logic [7:0] cmd_scope_type,
  input logic [15:0] cmd_length,
  input logic [2:0] cmd_initiator,
  // reserve-out parameter list
  input logic [63:0] par_key,
  input logic [63:0] par_sa_key,
  // reserve-in data stream
  output logic dout_valid,
  input logic dout_ready,
  output logic [7:0] dout_data,
  // completion
  output logic sts_valid,
  output prh_pkg::status_t sts_code,
  output prh_pkg::sense_t sts_sense,
  // task-set abort request
  output logic abort_valid,
  output logic [2:0] abort_id,
  // state
  output logic [31:0] generation
);

  prh_pkg::state_t st_q, st_d;
  prh_pkg::status_t code_q, code_d;
  prh_pkg::sense_t sense_q, sense_d;
  logic [31:0] gen_q, gen_d;
  logic [7:0] vld_q, vld_d;
  logic res_q, res_d;
  logic [2:0] res_id_q, res_id_d;
  logic [3:0] res_type_q, res_type_d;
  logic [63:0] res_key_q, res_key_d;
  logic [7:0] op_q, op_d;
  logic [4:0] sa_q, sa_d;
  logic [3:0] type_q, type_d;
  logic [15:0] len_q, len_d;
  logic [2:0] id_q, id_d;
  logic [63:0] key_q, key_d, sakey_q, sakey_d;
  logic [63:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d, idx_q, idx_d;
  logic [15:0] sent_q, sent_d;
  logic [1:0] chunk_q, chunk_d;
  logic abv_q, abv_d;
  logic [2:0] abid_q, abid_d;
  logic re, we, wvld;
  logic [2:0] raddr;
  logic [63:0] rdata;
  logic key_ok, type_ok, out_ok, bumps;

  function automatic logic [3:0] popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  prh_key_ram u_keys (
    .clk(clk),
    .we(we),
    .waddr(id_q),
    .wdata(sakey_q),
    .re(re),
    .raddr(raddr),
    .rdata(rdata)
  );

  // ==========================================================
  // reserve-out checks, valid while in S_CHECK
  assign key_ok = vld_q[id_q] && (rdata == key_q); // [RULE_20]
  assign type_ok = (type_q == `PRH_TYPE_WR_EXCL) || (type_q == `PRH_TYPE_EXCL) ||
    (type_q == `PRH_TYPE_WR_EXCL_REG) || (type_q == `PRH_TYPE_EXCL_REG); // [RULE_19]
  assign out_ok = !legacy_reserved && (len_q == `PRH_PARAM_LEN) &&
    (sa_q <= `PRH_SA_REGISTER_IGNORE) &&
    (key_ok || sa_q == `PRH_SA_REGISTER || sa_q == `PRH_SA_REGISTER_IGNORE) &&
    (type_ok || !(sa_q == `PRH_SA_RESERVE || sa_q == `PRH_SA_PREEMPT ||
    sa_q == `PRH_SA_PREEMPT_ABORT));
  // reserve and release never touch the counter
  assign bumps = (sa_q == `PRH_SA_REGISTER) || (sa_q == `PRH_SA_REGISTER_IGNORE) ||
    (sa_q == `PRH_SA_CLEAR) || (sa_q == `PRH_SA_PREEMPT) ||
    (sa_q == `PRH_SA_PREEMPT_ABORT); // [RULE_01] [RULE_02]

  assign cmd_ready = (st_q == prh_pkg::S_IDLE);
  assign dout_valid = (st_q == prh_pkg::S_SEND) && (sent_q != len_q); // [RULE_06]
  assign dout_data = sh_q[63:56];
  assign sts_valid = (st_q == prh_pkg::S_DONE);
  assign sts_code = code_q;
  assign sts_sense = sense_q;
  assign abort_valid = abv_q;
  assign abort_id = abid_q;
  assign generation = gen_q;

  // ==========================================================
  // command sequencer
  always_comb
  begin
    st_d = st_q;
    code_d = code_q;
    sense_d = sense_q;
    gen_d = gen_q;
    vld_d = vld_q;
    res_d = res_q;
    res_id_d = res_id_q;
    res_type_d = res_type_q;
    res_key_d = res_key_q;
    op_d = op_q;
    sa_d = sa_q;
    type_d = type_q;
    len_d = len_q;
    id_d = id_q;
    key_d = key_q;
    sakey_d = sakey_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    sent_d = sent_q;
    chunk_d = chunk_q;
    abv_d = 1'b0;
    abid_d = abid_q;
    re = 1'b0;
    we = 1'b0;
    wvld = 1'b0;
    raddr = id_q;
    unique case (st_q)
      prh_pkg::S_IDLE:
      begin
        if (cmd_valid)
        begin
          op_d = cmd_opcode; // [RULE_11]
          sa_d = cmd_action;
          type_d = cmd_scope_type[3:0];
          len_d = cmd_length;
          id_d = cmd_initiator;
          key_d = par_key;
          sakey_d = par_sa_key;
          re = 1'b1;
          raddr = cmd_initiator;
          st_d = prh_pkg::S_CHECK;
        end
      end
      prh_pkg::S_CHECK:
      begin
        code_d = prh_pkg::STS_GOOD;
        sense_d = prh_pkg::SNS_NONE;
        st_d = prh_pkg::S_DONE;
        idx_d = 4'h0;
        sent_d = 16'h0;
        chunk_d = 2'h0;
        cnt_d = `PRH_KEY_BYTES;
        if (op_q == `PRH_OP_IN)
        begin
          if (sa_q > `PRH_IN_LAST)
          begin
            code_d = prh_pkg::STS_CHECK; // [RULE_18]
            sense_d = prh_pkg::SNS_BAD_FIELD;
          end
          else
          begin
            // lengths count the whole list, whatever the allocation
            sh_d = {gen_q, 32'h0}; // [RULE_04] [RULE_08]
            if (sa_q == `PRH_IN_READ_KEYS)
            begin
              sh_d[31:0] = {25'h0, popcount(vld_q), 3'h0}; // [RULE_05] [RULE_07]
            end
            else if (sa_q == `PRH_IN_READ_RES && res_q)
            begin
              sh_d[31:0] = `PRH_DESC_BYTES; // [RULE_10]
            end
            st_d = prh_pkg::S_SEND;
          end
        end
        else if (op_q != `PRH_OP_OUT)
        begin
          code_d = prh_pkg::STS_CHECK;
          sense_d = prh_pkg::SNS_BAD_FIELD;
        end
        else if (legacy_reserved)
        begin
          code_d = prh_pkg::STS_CONFLICT; // [RULE_13]
        end
        else if (len_q != `PRH_PARAM_LEN)
        begin
          code_d = prh_pkg::STS_CHECK; // [RULE_12]
          sense_d = prh_pkg::SNS_PARAM_LEN;
        end
        else if (sa_q > `PRH_SA_REGISTER_IGNORE)
        begin
          code_d = prh_pkg::STS_CHECK; // [RULE_14]
          sense_d = prh_pkg::SNS_BAD_FIELD;
        end
        else if (!out_ok && !type_ok && key_ok)
        begin
          code_d = prh_pkg::STS_CHECK; // [RULE_19]
          sense_d = prh_pkg::SNS_BAD_FIELD;
        end
        else if (!out_ok)
        begin
          code_d = prh_pkg::STS_CONFLICT; // [RULE_20]
        end
        else
        begin
          if (bumps)
          begin
            gen_d = gen_q + 32'h1; // [RULE_01] [RULE_21]
          end
          unique case (sa_q)
            `PRH_SA_REGISTER, `PRH_SA_REGISTER_IGNORE:
            begin
              // a zero key unregisters and drops the reservation if this initiator holds it
              we = 1'b1;
              wvld = (sakey_q != 64'h0);
              vld_d[id_q] = wvld;
              if (!wvld && res_q && res_id_q == id_q)
              begin
                res_d = 1'b0;
              end
            end
            `PRH_SA_RESERVE:
            begin
              if (res_q && res_id_q != id_q)
              begin
                code_d = prh_pkg::STS_CONFLICT;
              end
              else
              begin
                res_d = 1'b1;
                res_id_d = id_q;
                res_type_d = type_q;
                res_key_d = key_q;
              end
            end
            `PRH_SA_RELEASE:
            begin
              if (res_q && res_id_q == id_q)
              begin
                res_d = 1'b0;
              end
            end
            `PRH_SA_CLEAR:
            begin
              vld_d = 8'h00; // [RULE_15]
              res_d = 1'b0;
            end
            default:
            begin
              // preempt: take the reservation if its key matches the service-action key, then sweep victim keys
              if (res_q && res_key_q == sakey_q)
              begin
                res_id_d = id_q;
                res_type_d = type_q;
                res_key_d = key_q;
              end
              st_d = prh_pkg::S_SCAN;
            end
          endcase
        end
      end
      prh_pkg::S_SCAN:
      begin
        if (idx_q[3])
        begin
          st_d = prh_pkg::S_DONE;
        end
        else if (vld_q[idx_q[2:0]] && idx_q[2:0] != id_q)
        begin
          re = 1'b1;
          raddr = idx_q[2:0];
          st_d = prh_pkg::S_SCMP;
        end
        else
        begin
          idx_d = idx_q + 4'h1;
        end
      end
      prh_pkg::S_SCMP:
      begin
        if (rdata == sakey_q)
        begin
          vld_d[idx_q[2:0]] = 1'b0;
          abv_d = (sa_q == `PRH_SA_PREEMPT_ABORT); // [RULE_16]
          abid_d = idx_q[2:0];
        end
        idx_d = idx_q + 4'h1;
        st_d = prh_pkg::S_SCAN;
      end
      prh_pkg::S_FETCH:
      begin
        if (idx_q[3])
        begin
          st_d = prh_pkg::S_DONE;
        end
        else if (vld_q[idx_q[2:0]])
        begin
          re = 1'b1; // [RULE_07]
          raddr = idx_q[2:0];
          st_d = prh_pkg::S_LOAD;
        end
        else
        begin
          idx_d = idx_q + 4'h1;
        end
      end
      prh_pkg::S_LOAD:
      begin
        sh_d = rdata;
        cnt_d = `PRH_KEY_BYTES;
        idx_d = idx_q + 4'h1;
        st_d = prh_pkg::S_SEND;
      end
      prh_pkg::S_SEND:
      begin
        if (sent_q == len_q)
        begin
          // truncated silently: status stays good
          st_d = prh_pkg::S_DONE; // [RULE_06]
        end
        else if (dout_ready)
        begin
          sh_d = {sh_q[55:0], 8'h00};
          sent_d = sent_q + 16'h1;
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            cnt_d = `PRH_KEY_BYTES;
            chunk_d = chunk_q + 2'h1;
            if (sa_q == `PRH_IN_READ_KEYS)
            begin
              st_d = prh_pkg::S_FETCH;
            end
            else if (sa_q == `PRH_IN_READ_RES && res_q && chunk_q == 2'h0)
            begin
              sh_d = res_key_q; // [RULE_09]
            end
            else if (sa_q == `PRH_IN_READ_RES && res_q && chunk_q == 2'h1)
            begin
              sh_d = {32'h0, 8'h00, 4'h0, res_type_q, 16'h0000}; // [RULE_09]
            end
            else
            begin
              st_d = prh_pkg::S_DONE;
            end
          end
        end
      end
      prh_pkg::S_DONE:
      begin
        st_d = prh_pkg::S_IDLE;
      end
    endcase
    if (hard_reset)
    begin
      gen_d = `PRH_GEN_RESET; // [RULE_03]
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= prh_pkg::S_IDLE;
      code_q <= prh_pkg::STS_GOOD;
      sense_q <= prh_pkg::SNS_NONE;
      gen_q <= `PRH_GEN_RESET; // [RULE_03]
      vld_q <= 8'h00;
      res_q <= 1'b0;
      res_id_q <= 3'h0;
      res_type_q <= 4'h0;
      res_key_q <= 64'h0;
      op_q <= 8'h00;
      sa_q <= 5'h00;
      type_q <= 4'h0;
      len_q <= 16'h0000;
      id_q <= 3'h0;
      key_q <= 64'h0;
      sakey_q <= 64'h0;
      sh_q <= 64'h0;
      cnt_q <= 4'h0;
      idx_q <= 4'h0;
      sent_q <= 16'h0000;
      chunk_q <= 2'h0;
      abv_q <= 1'b0;
      abid_q <= 3'h0;
    end
    else
    begin
      st_q <= st_d;
      code_q <= code_d;
      sense_q <= sense_d;
      gen_q <= gen_d;
      vld_q <= vld_d;
      res_q <= res_d;
      res_id_q <= res_id_d;
      res_type_q <= res_type_d;
      res_key_q <= res_key_d;
      op_q <= op_d;
      sa_q <= sa_d;
      type_q <= type_d;
      len_q <= len_d;
      id_q <= id_d;
      key_q <= key_d;
      sakey_q <= sakey_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sent_q <= sent_d;
      chunk_q <= chunk_d;
      abv_q <= abv_d;
      abid_q <= abid_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic chk_out;
  assign chk_out = (st_q == prh_pkg::S_CHECK) && (op_q == `PRH_OP_OUT);

  gen_reset_a: assert property (hard_reset |=> gen_q == 32'h0) // [RULE_03]
    else $error("generation not cleared by hard reset");
  gen_inc_a: assert property (chk_out && out_ok && bumps && !hard_reset
    |=> gen_q == $past(gen_q) + 32'h1) // [RULE_01]
    else $error("generation did not advance");
  gen_hold_a: assert property ((st_q == prh_pkg::S_CHECK) && !(chk_out && out_ok && bumps)
    && !hard_reset |=> $stable(gen_q)) // [RULE_02]
    else $error("generation moved without cause");
  trunc_len_a: assert property (dout_valid |-> sent_q < len_q) // [RULE_06]
    else $error("byte sent past allocation length");
  legacy_conflict_a: assert property (chk_out && legacy_reserved
    |=> sts_valid && sts_code == prh_pkg::STS_CONFLICT) // [RULE_13]
    else $error("legacy reserve not answered with conflict");
  param_len_a: assert property (chk_out && !legacy_reserved && len_q != `PRH_PARAM_LEN
    |=> sts_valid && sts_sense == prh_pkg::SNS_PARAM_LEN) // [RULE_12]
    else $error("bad parameter length not flagged");
  out_action_a: assert property (chk_out && !legacy_reserved && len_q == `PRH_PARAM_LEN
    && sa_q > `PRH_SA_REGISTER_IGNORE |=> sts_sense == prh_pkg::SNS_BAD_FIELD) // [RULE_14]
    else $error("reserved action accepted");
  in_action_a: assert property ((st_q == prh_pkg::S_CHECK) && op_q == `PRH_OP_IN
    && sa_q > `PRH_IN_LAST |=> sts_code == prh_pkg::STS_CHECK) // [RULE_18]
    else $error("reserved reserve-in action accepted");
  clear_all_a: assert property (chk_out && out_ok && sa_q == `PRH_SA_CLEAR
    |=> vld_q == 8'h00 && !res_q) // [RULE_15]
    else $error("clear left keys or reservation");
  hdr_gen_a: assert property ((st_q == prh_pkg::S_SEND) && sent_q == 16'h0 && dout_valid
    |-> dout_data == gen_q[31:24]) // [RULE_04]
    else $error("response does not open with generation");

  trunc_c: cover property (dout_valid ##1 (st_q == prh_pkg::S_SEND) && sent_q == len_q);
  abort_c: cover property (abort_valid);
  keys_c: cover property ((st_q == prh_pkg::S_LOAD) ##[1:20] sts_valid);

endmodule

// [prh_host.sv]
`timescale 1ns/1ps
// ==========================================================
// initiator model: one command at a time, byte sink that can stall
module prh_host (
  // clock
  input logic clk,
  // command block and parameter list
  output logic cmd_valid,
  input logic cmd_ready,
  output logic [7:0] cmd_opcode,
  output logic [4:0] cmd_action,
  output logic [7:0] cmd_scope_type,
  output logic [15:0] cmd_length,
  output logic [2:0] cmd_initiator,
  output logic [63:0] par_key,
  output logic [63:0] par_sa_key,
  // returned data, status and aborts
  input logic dout_valid,
  output logic dout_ready,
  input logic [7:0] dout_data,
  input logic sts_valid,
  input prh_pkg::status_t sts_code,
  input prh_pkg::sense_t sts_sense,
  input logic abort_valid,
  input logic [2:0] abort_id
);
  logic [7:0] rx_q[$];
  logic [2:0] ab_q[$];
  prh_pkg::status_t code;
  prh_pkg::sense_t sense;
  logic slow;

  initial
  begin
    cmd_valid = 1'b0;
    {cmd_opcode, cmd_action, cmd_scope_type, cmd_length, cmd_initiator} = '0;
    {par_key, par_sa_key} = '0;
    dout_ready = 1'b1;
    slow = 1'b0;
  end

  // slow mode stalls the byte stream every other cycle
  always @(posedge clk)
    dout_ready <= slow ? ~dout_ready : 1'b1;

  task automatic issue(input logic [7:0] op, input logic [4:0] act, input logic [3:0] typ,
    input logic [15:0] len, input logic [2:0] ini, input logic [63:0] key,
    input logic [63:0] sak);
    int n;
    logic done;
    begin
      n = 0;
      done = 1'b0;
      // a lost completion leaves an impossible code, so a hang cannot match
      code = prh_pkg::status_t'(2'h3);
      sense = prh_pkg::sense_t'(2'h3);
      rx_q.delete();
      ab_q.delete();
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      cmd_action <= act;
      cmd_scope_type <= {4'h0, typ};
      cmd_length <= len;
      cmd_initiator <= ini;
      par_key <= key;
      par_sa_key <= sak;
      @(posedge clk);
      while (cmd_ready !== 1'b1 && n < 50)
      begin
        @(posedge clk);
        n++;
      end
      // released opcode, action, length and keys carry the inverse, so a late sample cannot look valid
      cmd_valid <= 1'b0;
      cmd_opcode <= ~op;
      cmd_action <= ~act;
      cmd_length <= ~len;
      par_key <= ~key;
      par_sa_key <= ~sak;
      while (!done && n < 600)
      begin
        @(posedge clk);
        n++;
        if (dout_valid === 1'b1 && dout_ready === 1'b1)
          rx_q.push_back(dout_data);
        if (abort_valid === 1'b1)
          ab_q.push_back(abort_id);
        if (sts_valid === 1'b1)
        begin
          code = sts_code;
          sense = sts_sense;
          done = 1'b1;
        end
      end
    end
  endtask
endmodule

// [persistent_reservation_handler_tb.sv]
`timescale 1ns/1ps
`include "prh_defines.svh"
`define check_eq(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module persistent_reservation_handler_tb;
  logic clk, arst_n, hard_reset, legacy_reserved;
  logic cmd_valid, cmd_ready, dout_valid, dout_ready, sts_valid, abort_valid;
  logic [7:0] cmd_opcode, cmd_scope_type, dout_data;
  logic [4:0] cmd_action;
  logic [15:0] cmd_length;
  logic [2:0] cmd_initiator, abort_id;
  logic [63:0] par_key, par_sa_key;
  prh_pkg::status_t sts_code;
  prh_pkg::sense_t sts_sense;
  logic [31:0] generation;
  int error_cnt;
  int n_checks;
  logic [31:0] gen_e;
  logic [7:0] exp_q[$];
  localparam logic [63:0] KEY_A = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] KEY_B = 64'hFEDC_BA98_7654_3210;

  persistent_reservation_handler persistent_reservation_handler_inst (
    .clk(clk), .arst_n(arst_n), .hard_reset(hard_reset), .legacy_reserved(legacy_reserved),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_action(cmd_action), .cmd_scope_type(cmd_scope_type), .cmd_length(cmd_length),
    .cmd_initiator(cmd_initiator), .par_key(par_key), .par_sa_key(par_sa_key),
    .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_data(dout_data),
    .sts_valid(sts_valid), .sts_code(sts_code), .sts_sense(sts_sense),
    .abort_valid(abort_valid), .abort_id(abort_id), .generation(generation));

  prh_host prh_host_inst (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_action(cmd_action), .cmd_scope_type(cmd_scope_type), .cmd_length(cmd_length),
    .cmd_initiator(cmd_initiator), .par_key(par_key), .par_sa_key(par_sa_key),
    .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_data(dout_data),
    .sts_valid(sts_valid), .sts_code(sts_code), .sts_sense(sts_sense),
    .abort_valid(abort_valid), .abort_id(abort_id));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // shared helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic pushv(input logic [63:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--)
      exp_q.push_back(v[i * 8 +: 8]);
  endtask

  task automatic chk_rx(input int alloc, input string nm);
    int n;
    n = (exp_q.size() < alloc) ? exp_q.size() : alloc;
    `check_eq(nm, n, prh_host_inst.rx_q.size())
    for (int i = 0; i < n && i < prh_host_inst.rx_q.size(); i++)
      `check_eq(nm, exp_q[i], prh_host_inst.rx_q[i])
    exp_q.delete();
  endtask

  task automatic exp_sts(input prh_pkg::status_t c, input prh_pkg::sense_t s, input string nm);
    `check_eq(nm, c, prh_host_inst.code)
    `check_eq(nm, s, prh_host_inst.sense)
    `check_eq(nm, gen_e, generation)
  endtask

  task automatic rd(input logic [4:0] act, input logic [15:0] len);
    prh_host_inst.issue(`PRH_OP_IN, act, 4'h0, len, 3'h0, 64'h0, 64'h0);
  endtask

  task automatic pr_out(input logic [4:0] act, input logic [3:0] typ, input logic [2:0] ini,
    input logic [63:0] key, input logic [63:0] sak);
    prh_host_inst.issue(`PRH_OP_OUT, act, typ, `PRH_PARAM_LEN, ini, key, sak);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_keys;
    `check_eq("gen_reset", 32'h0000_0000, generation)
    pr_out(`PRH_SA_REGISTER, 4'h0, 3'h0, 64'h0, KEY_A);
    gen_e++;
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "register");
    pr_out(`PRH_SA_REGISTER_IGNORE, 4'h0, 3'h2, 64'h0, KEY_B);
    gen_e++;
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "register_ignore");
    prh_host_inst.slow = 1'b1;
    rd(`PRH_IN_READ_KEYS, 16'h0064);
    pushv(gen_e, 4); pushv(64'h10, 4); pushv(KEY_A, 8); pushv(KEY_B, 8);
    chk_rx(100, "read_keys");
    rd(`PRH_IN_READ_KEYS, 16'h000A);
    pushv(gen_e, 4); pushv(64'h10, 4); pushv(KEY_A, 8);
    chk_rx(10, "keys_trunc");
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "trunc_sts");
    prh_host_inst.slow = 1'b0;
    $display("test keys done");
  endtask

  task automatic t_reserve;
    pr_out(`PRH_SA_RESERVE, `PRH_TYPE_EXCL, 3'h0, KEY_A, 64'h0);
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "reserve");
    rd(`PRH_IN_READ_RES, 16'h0064);
    pushv(gen_e, 4); pushv(64'h10, 4); pushv(KEY_A, 8); pushv(64'h0000_0000_0003_0000, 8);
    chk_rx(100, "read_res");
    rd(`PRH_IN_READ_RES, 16'h0009);
    pushv(gen_e, 4); pushv(64'h10, 4); pushv(KEY_A, 8);
    chk_rx(9, "res_trunc");
    rd(5'h02, 16'h0064);
    pushv(gen_e, 4); pushv(64'h0, 4);
    chk_rx(100, "capabilities");
    $display("test reserve done");
  endtask

  task automatic t_errors;
    prh_host_inst.issue(`PRH_OP_OUT, `PRH_SA_CLEAR, 4'h0, 16'h0019, 3'h0, KEY_A, 64'h0);
    exp_sts(prh_pkg::STS_CHECK, prh_pkg::SNS_PARAM_LEN, "param_len");
    // legacy reserve raised only here to provoke the conflict
    @(posedge clk);
    legacy_reserved <= 1'b1;
    pr_out(`PRH_SA_REGISTER, 4'h0, 3'h0, KEY_A, KEY_A);
    exp_sts(prh_pkg::STS_CONFLICT, prh_pkg::SNS_NONE, "legacy");
    legacy_reserved <= 1'b0;
    for (int a = 7; a < 32; a++)
    begin
      pr_out(a[4:0], `PRH_TYPE_EXCL, 3'h0, KEY_A, 64'h0);
      exp_sts(prh_pkg::STS_CHECK, prh_pkg::SNS_BAD_FIELD, "sa_reserved");
    end
    for (int a = 4; a < 32; a++)
    begin
      rd(a[4:0], 16'h0064);
      exp_sts(prh_pkg::STS_CHECK, prh_pkg::SNS_BAD_FIELD, "in_reserved");
    end
    pr_out(`PRH_SA_RESERVE, 4'h2, 3'h0, KEY_A, 64'h0);
    exp_sts(prh_pkg::STS_CHECK, prh_pkg::SNS_BAD_FIELD, "type_reserved");
    prh_host_inst.issue(8'h12, 5'h00, 4'h0, 16'h0018, 3'h0, KEY_A, 64'h0);
    exp_sts(prh_pkg::STS_CHECK, prh_pkg::SNS_BAD_FIELD, "opcode");
    pr_out(`PRH_SA_RELEASE, `PRH_TYPE_EXCL, 3'h0, KEY_B, 64'h0);
    exp_sts(prh_pkg::STS_CONFLICT, prh_pkg::SNS_NONE, "key_mismatch");
    $display("test errors done");
  endtask

  task automatic t_preempt_clear;
    pr_out(`PRH_SA_PREEMPT_ABORT, `PRH_TYPE_EXCL, 3'h2, KEY_B, KEY_A);
    gen_e++;
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "preempt_abort");
    `check_eq("abort_count", 1, prh_host_inst.ab_q.size())
    `check_eq("abort_id", 3'h0, prh_host_inst.ab_q[0])
    rd(`PRH_IN_READ_KEYS, 16'h0064);
    pushv(gen_e, 4); pushv(64'h8, 4); pushv(KEY_B, 8);
    chk_rx(100, "keys_after_preempt");
    pr_out(`PRH_SA_CLEAR, 4'h0, 3'h2, KEY_B, 64'h0);
    gen_e++;
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "clear");
    rd(`PRH_IN_READ_KEYS, 16'h0064);
    pushv(gen_e, 4); pushv(64'h0, 4);
    chk_rx(100, "keys_after_clear");
    rd(`PRH_IN_READ_RES, 16'h0064);
    pushv(gen_e, 4); pushv(64'h0, 4);
    chk_rx(100, "res_after_clear");
    $display("test preempt and clear done");
  endtask

  task automatic t_hard;
    @(posedge clk);
    hard_reset <= 1'b1;
    @(posedge clk);
    hard_reset <= 1'b0;
    @(posedge clk);
    gen_e = 32'h0000_0000;
    `check_eq("gen_hard", gen_e, generation)
    pr_out(`PRH_SA_REGISTER, 4'h0, 3'h1, 64'h0, KEY_A);
    gen_e++;
    exp_sts(prh_pkg::STS_GOOD, prh_pkg::SNS_NONE, "reg_after_hard");
    $display("test hard reset done");
  endtask

  initial
  begin
    arst_n = 1'b0;
    hard_reset = 1'b0;
    legacy_reserved = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    gen_e = 32'h0000_0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_keys();
    t_reserve();
    t_errors();
    t_preempt_clear();
    t_hard();
    complete_run();
  end

  // the whole run needs well under two thousand cycles
  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end
endmodule
